// *** hw/branch_skip_call_exec.sv ***
// execution unit for calls, returns, compares, skips and conditional branches
`timescale 1ns/100ps

// Contract
// RULE_01 - calls push return, jump in 3/3/4 cycles
// RULE_02 - returns pop PC in 4; interrupt exit sets I
// RULE_03 - equal_skip skips next instruction when registers equal
// RULE_04 - compares set Z N V C H, no write, 1 cycle
// RULE_05 - reg_bit_clear_skip skips when register bit is 0
// RULE_06 - reg_bit_set_skip skips when register bit is 1
// RULE_07 - io_bit_clear_skip skips when I/O bit is 0
// RULE_08 - io_bit_set_skip skips when I/O bit is 1
// RULE_09 - flag_set_branch taken when selected flag is 1
// RULE_10 - flag_clear_branch taken when selected flag is 0
// RULE_11 - zero branches follow Z, 1 or 2 cycles
// RULE_12 - carry and unsigned branches follow C
// RULE_13 - negative branches follow N
// RULE_14 - signed branches follow N xor V
// RULE_15 - half-carry branches follow H
// RULE_16 - transfer-bit branches follow T
// RULE_17 - skip one word: 2 cycles; two words: 3
module branch_skip_call_exec #(
  parameter int PC_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              op_valid,
  input  wire exec_pkg::op_t     op,
  input  wire logic [PC_W-1:0]   pc_in,
  input  wire logic [11:0]       rel_offset,
  input  wire logic [PC_W-1:0]   abs_target,
  input  wire logic [PC_W-1:0]   z_pointer,
  input  wire logic [7:0]        rd_val,
  input  wire logic [7:0]        rr_val,
  input  wire logic [7:0]        imm_val,
  input  wire logic [2:0]        bit_sel,
  input  wire logic [2:0]        flag_sel,
  input  wire logic [7:0]        io_data,
  input  wire logic [7:0]        status_in,
  input  wire logic              next_is_two_word,
  input  wire logic [PC_W-1:0]   stack_data,
  output logic                   busy,
  output logic                   done,
  output logic [PC_W-1:0]        pc_out,
  output logic                   flags_we,
  output logic [7:0]             flags_out,
  output logic                   push_valid,
  output logic [PC_W-1:0]        push_data,
  output logic                   pop_req,
  output logic                   skip_taken,
  output logic                   branch_taken
);

  // elaboration check: relative offsets must fit the program counter
  if (PC_W < 12 || PC_W > 32) begin : g_bad_pc_w
    $error("PC_W must lie between 12 and 32");
  end

  logic            issue;
  logic [PC_W-1:0] rel_ext;
  logic [PC_W-1:0] next_target;
  logic [2:0]      next_cycles;
  logic [7:0]      next_flags;
  logic            next_flags_we;
  logic            next_push;
  logic [PC_W-1:0] next_push_data;
  logic            next_pop;
  logic            next_skip;
  logic            next_branch;
  logic            cond;
  logic            is_skip;
  logic            is_branch;
  logic [7:0]      cmp_b;
  logic            cmp_borrow;
  logic [8:0]      cmp_diff;
  logic [7:0]      cmp_res;
  logic [1:0]      skip_adv;
  logic [2:0]      skip_cyc;

  // pending results held while a multi-cycle operation runs
  logic [2:0]      cnt;
  logic [PC_W-1:0] target;
  logic [7:0]      flags_pend;
  logic            flags_we_pend;
  logic            skip_pend;
  logic            branch_pend;
  logic            pop_wait;
  logic            ret_pend;

  assign issue   = op_valid && !busy;
  assign rel_ext = {{(PC_W-12){rel_offset[11]}}, rel_offset};

  // compare datapath: subtract without writing back
  always_comb begin
    cmp_b      = (op == exec_pkg::OP_COMPARE_IMMEDIATE) ? imm_val : rr_val;
    cmp_borrow = (op == exec_pkg::OP_COMPARE_WITH_BORROW) && status_in[exec_pkg::FLAG_C];
    cmp_diff   = {1'b0, rd_val} - {1'b0, cmp_b} - {8'h00, cmp_borrow}; // [RULE_04]
    cmp_res    = cmp_diff[7:0];
  end

  // skip length depends on the width of the instruction being skipped
  always_comb begin
    skip_adv = next_is_two_word ? exec_pkg::ADV_SKIP_TWO : exec_pkg::ADV_SKIP_ONE; // [RULE_17]
    skip_cyc = next_is_two_word ? exec_pkg::CYC_SKIP_TWO : exec_pkg::CYC_SKIP_ONE; // [RULE_17]
  end

  // condition for every skip and branch
  always_comb begin
    cond      = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b0;
    case (op)
      exec_pkg::OP_EQUAL_SKIP: begin
        is_skip = 1'b1;
        cond    = (rd_val == rr_val); // [RULE_03]
      end
      exec_pkg::OP_REG_BIT_CLEAR_SKIP: begin
        is_skip = 1'b1;
        cond    = !rr_val[bit_sel]; // [RULE_05]
      end
      exec_pkg::OP_REG_BIT_SET_SKIP: begin
        is_skip = 1'b1;
        cond    = rr_val[bit_sel]; // [RULE_06]
      end
      exec_pkg::OP_IO_BIT_CLEAR_SKIP: begin
        is_skip = 1'b1;
        cond    = !io_data[bit_sel]; // [RULE_07]
      end
      exec_pkg::OP_IO_BIT_SET_SKIP: begin
        is_skip = 1'b1;
        cond    = io_data[bit_sel]; // [RULE_08]
      end
      exec_pkg::OP_FLAG_SET_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[flag_sel]; // [RULE_09]
      end
      exec_pkg::OP_FLAG_CLEAR_BRANCH: begin
        is_branch = 1'b1;
        cond      = !status_in[flag_sel]; // [RULE_10]
      end
      exec_pkg::OP_ZERO_SET_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[exec_pkg::FLAG_Z]; // [RULE_11]
      end
      exec_pkg::OP_ZERO_CLEAR_BRANCH: begin
        is_branch = 1'b1;
        cond      = !status_in[exec_pkg::FLAG_Z]; // [RULE_11]
      end
      exec_pkg::OP_CARRY_SET_BRANCH, exec_pkg::OP_UNSIGNED_LT_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[exec_pkg::FLAG_C]; // [RULE_12]
      end
      exec_pkg::OP_CARRY_CLEAR_BRANCH, exec_pkg::OP_UNSIGNED_GE_BRANCH: begin
        is_branch = 1'b1;
        cond      = !status_in[exec_pkg::FLAG_C]; // [RULE_12]
      end
      exec_pkg::OP_NEGATIVE_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[exec_pkg::FLAG_N]; // [RULE_13]
      end
      exec_pkg::OP_NONNEGATIVE_BRANCH: begin
        is_branch = 1'b1;
        cond      = !status_in[exec_pkg::FLAG_N]; // [RULE_13]
      end
      exec_pkg::OP_SIGNED_GE_BRANCH: begin
        is_branch = 1'b1;
        cond      = !(status_in[exec_pkg::FLAG_N] ^ status_in[exec_pkg::FLAG_V]); // [RULE_14]
      end
      exec_pkg::OP_SIGNED_LT_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[exec_pkg::FLAG_N] ^ status_in[exec_pkg::FLAG_V]; // [RULE_14]
      end
      exec_pkg::OP_HALF_CARRY_SET_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[exec_pkg::FLAG_H]; // [RULE_15]
      end
      exec_pkg::OP_HALF_CARRY_CLEAR_BRANCH: begin
        is_branch = 1'b1;
        cond      = !status_in[exec_pkg::FLAG_H]; // [RULE_15]
      end
      exec_pkg::OP_TRANSFER_BIT_SET_BRANCH: begin
        is_branch = 1'b1;
        cond      = status_in[exec_pkg::FLAG_T]; // [RULE_16]
      end
      exec_pkg::OP_TRANSFER_BIT_CLEAR_BRANCH: begin
        is_branch = 1'b1;
        cond      = !status_in[exec_pkg::FLAG_T]; // [RULE_16]
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // target, cycle count, flags and stack traffic for the issued operation
  always_comb begin
    next_target    = pc_in + PC_W'(exec_pkg::ADV_NEXT);
    next_cycles    = exec_pkg::CYC_SINGLE;
    next_flags     = status_in;
    next_flags_we  = 1'b0;
    next_push      = 1'b0;
    next_push_data = pc_in + PC_W'(exec_pkg::ADV_NEXT);
    next_pop       = 1'b0;
    next_skip      = is_skip && cond;
    next_branch    = is_branch && cond;
    case (op)
      exec_pkg::OP_RELATIVE_JUMP_LINK: begin
        next_target = pc_in + rel_ext + PC_W'(exec_pkg::ADV_NEXT); // [RULE_01]
        next_cycles = exec_pkg::CYC_REL_LINK;
        next_push   = 1'b1;
      end
      exec_pkg::OP_POINTER_JUMP_LINK: begin
        next_target = z_pointer; // [RULE_01]
        next_cycles = exec_pkg::CYC_PTR_LINK;
        next_push   = 1'b1;
      end
      exec_pkg::OP_DIRECT_JUMP_LINK: begin
        next_target    = abs_target; // [RULE_01]
        next_cycles    = exec_pkg::CYC_DIR_LINK;
        next_push      = 1'b1;
        next_push_data = pc_in + PC_W'(exec_pkg::ADV_SKIP_ONE); // two-word call
      end
      exec_pkg::OP_POP_TO_PC_EXIT: begin
        next_cycles = exec_pkg::CYC_RETURN; // [RULE_02]
        next_pop    = 1'b1;
      end
      exec_pkg::OP_INTERRUPT_EXIT: begin
        next_cycles                  = exec_pkg::CYC_RETURN; // [RULE_02]
        next_pop                     = 1'b1;
        next_flags[exec_pkg::FLAG_I] = 1'b1; // [RULE_02]
        next_flags_we                = 1'b1;
      end
      exec_pkg::OP_COMPARE, exec_pkg::OP_COMPARE_WITH_BORROW,
      exec_pkg::OP_COMPARE_IMMEDIATE: begin
        next_flags_we                = 1'b1; // [RULE_04]
        next_flags[exec_pkg::FLAG_C] = cmp_diff[8];
        next_flags[exec_pkg::FLAG_N] = cmp_res[7];
        next_flags[exec_pkg::FLAG_V] = (rd_val[7] & ~cmp_b[7] & ~cmp_res[7])
                                     | (~rd_val[7] & cmp_b[7] & cmp_res[7]);
        next_flags[exec_pkg::FLAG_S] = next_flags[exec_pkg::FLAG_N] ^ next_flags[exec_pkg::FLAG_V];
        next_flags[exec_pkg::FLAG_H] = (~rd_val[3] & cmp_b[3]) | (cmp_b[3] & cmp_res[3])
                                     | (cmp_res[3] & ~rd_val[3]);
        // borrow form keeps Z only if it was already set
        next_flags[exec_pkg::FLAG_Z] = (cmp_res == 8'h00) &&
          ((op != exec_pkg::OP_COMPARE_WITH_BORROW) || status_in[exec_pkg::FLAG_Z]);
      end
      default: begin
        if (next_skip) begin
          next_target = pc_in + PC_W'(skip_adv); // [RULE_17]
          next_cycles = skip_cyc;
        end else if (next_branch) begin
          next_target = pc_in + rel_ext + PC_W'(exec_pkg::ADV_NEXT);
          next_cycles = exec_pkg::CYC_BR_TAKEN;
        end
      end
    endcase
  end

  // cycle counter and busy flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt  <= 3'h0;
    end else if (issue) begin
      busy <= (next_cycles != exec_pkg::CYC_SINGLE);
      cnt  <= next_cycles - 3'h1;
    end else if (busy) begin
      cnt  <= cnt - 3'h1;
      busy <= (cnt != 3'h1);
    end
  end

  // pending results captured at issue, return address taken from the stack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      target        <= '0;
      flags_pend    <= exec_pkg::FLAGS_RESET;
      flags_we_pend <= 1'b0;
      skip_pend     <= 1'b0;
      branch_pend   <= 1'b0;
      ret_pend      <= 1'b0;
    end else if (issue) begin
      target        <= next_target;
      flags_pend    <= next_flags;
      flags_we_pend <= next_flags_we;
      skip_pend     <= next_skip;
      branch_pend   <= next_branch;
      ret_pend      <= next_pop;
    end else if (pop_wait) begin
      target <= stack_data; // [RULE_02]
    end
  end

  // stack requests go out in the cycle after issue
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      push_valid <= 1'b0;
      push_data  <= '0;
      pop_req    <= 1'b0;
      pop_wait   <= 1'b0;
    end else begin
      push_valid <= issue && next_push; // [RULE_01]
      pop_req    <= issue && next_pop; // [RULE_02]
      pop_wait   <= pop_req;
      if (issue && next_push) begin
        push_data <= next_push_data;
      end
    end
  end

  // completion: one-cycle operations finish at once, others when the count ends
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done         <= 1'b0;
      pc_out       <= '0;
      flags_we     <= 1'b0;
      flags_out    <= exec_pkg::FLAGS_RESET;
      skip_taken   <= 1'b0;
      branch_taken <= 1'b0;
    end else if (issue && next_cycles == exec_pkg::CYC_SINGLE) begin
      done         <= 1'b1; // [RULE_04]
      pc_out       <= next_target;
      flags_we     <= next_flags_we;
      flags_out    <= next_flags;
      skip_taken   <= 1'b0;
      branch_taken <= 1'b0;
    end else if (busy && cnt == 3'h1) begin
      done         <= 1'b1;
      pc_out       <= (ret_pend && pop_wait) ? stack_data : target;
      flags_we     <= flags_we_pend;
      flags_out    <= flags_pend;
      skip_taken   <= skip_pend;
      branch_taken <= branch_pend;
    end else begin
      done         <= 1'b0;
      flags_we     <= 1'b0;
      skip_taken   <= 1'b0;
      branch_taken <= 1'b0;
    end
  end

endmodule

// *** include/exec_pkg.sv ***
// shared constants and opcode type for the control-flow execution unit
package exec_pkg;

  // decoded control-flow and compare operations
  typedef enum logic [4:0] {
    OP_RELATIVE_JUMP_LINK,
    OP_POINTER_JUMP_LINK,
    OP_DIRECT_JUMP_LINK,
    OP_POP_TO_PC_EXIT,
    OP_INTERRUPT_EXIT,
    OP_EQUAL_SKIP,
    OP_COMPARE,
    OP_COMPARE_WITH_BORROW,
    OP_COMPARE_IMMEDIATE,
    OP_REG_BIT_CLEAR_SKIP,
    OP_REG_BIT_SET_SKIP,
    OP_IO_BIT_CLEAR_SKIP,
    OP_IO_BIT_SET_SKIP,
    OP_FLAG_SET_BRANCH,
    OP_FLAG_CLEAR_BRANCH,
    OP_ZERO_SET_BRANCH,
    OP_ZERO_CLEAR_BRANCH,
    OP_CARRY_SET_BRANCH,
    OP_CARRY_CLEAR_BRANCH,
    OP_UNSIGNED_GE_BRANCH,
    OP_UNSIGNED_LT_BRANCH,
    OP_NEGATIVE_BRANCH,
    OP_NONNEGATIVE_BRANCH,
    OP_SIGNED_GE_BRANCH,
    OP_SIGNED_LT_BRANCH,
    OP_HALF_CARRY_SET_BRANCH,
    OP_HALF_CARRY_CLEAR_BRANCH,
    OP_TRANSFER_BIT_SET_BRANCH,
    OP_TRANSFER_BIT_CLEAR_BRANCH
  } op_t;

  // bit positions inside status_flags_reg
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // cycle counts per operation class
  localparam logic [2:0] CYC_REL_LINK   = 3'h3;
  localparam logic [2:0] CYC_PTR_LINK   = 3'h3;
  localparam logic [2:0] CYC_DIR_LINK   = 3'h4;
  localparam logic [2:0] CYC_RETURN     = 3'h4;
  localparam logic [2:0] CYC_SINGLE     = 3'h1;
  localparam logic [2:0] CYC_BR_TAKEN   = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE   = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO   = 3'h3;

  // program counter advances
  localparam logic [1:0] ADV_NEXT     = 2'h1;
  localparam logic [1:0] ADV_SKIP_ONE = 2'h2;
  localparam logic [1:0] ADV_SKIP_TWO = 2'h3;

  // reset values of the registered outputs
  localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

// *** testbench/branch_skip_call_exec_props.sv ***
// concurrent checks on the ports of the control-flow execution unit
`timescale 1ns/100ps
module exec_checker #(
  parameter int PC_W = 16
) (
  input logic              core_clk,
  input logic              rst_n,
  input logic              op_valid,
  input exec_pkg::op_t     op,
  input logic [PC_W-1:0]   pc_in,
  input logic [11:0]       rel_offset,
  input logic [PC_W-1:0]   abs_target,
  input logic [PC_W-1:0]   z_pointer,
  input logic [7:0]        rd_val,
  input logic [7:0]        rr_val,
  input logic [7:0]        status_in,
  input logic              next_is_two_word,
  input logic [PC_W-1:0]   stack_data,
  input logic              busy,
  input logic              done,
  input logic [PC_W-1:0]   pc_out,
  input logic              flags_we,
  input logic [7:0]        flags_out,
  input logic              push_valid,
  input logic [PC_W-1:0]   push_data,
  input logic              pop_req,
  input logic              skip_taken,
  input logic              branch_taken
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic            issue;
  logic [PC_W-1:0] rel_tgt;
  logic [PC_W-1:0] nxt;
  logic [PC_W-1:0] nxt2;
  logic [PC_W-1:0] nxt3;
  // accepted request and the addresses derived from it
  assign issue = op_valid && !busy;
  assign rel_tgt = pc_in + {{(PC_W-12){rel_offset[11]}}, rel_offset} + 1'h1;
  assign nxt = pc_in + 2'h1;
  assign nxt2 = pc_in + 2'h2;
  assign nxt3 = pc_in + 2'h3;

  chk_rel_call:
    assert property (issue && op == exec_pkg::OP_RELATIVE_JUMP_LINK |-> ##1 push_valid
      && push_data == $past(nxt) ##2 done && pc_out == $past(rel_tgt, 3))
      else $error("relative call push or target wrong");
  chk_ptr_call:
    assert property (issue && op == exec_pkg::OP_POINTER_JUMP_LINK |-> ##3 done
      && pc_out == $past(z_pointer, 3)) else $error("pointer call target wrong");
  chk_dir_call:
    assert property (issue && op == exec_pkg::OP_DIRECT_JUMP_LINK |-> ##1 push_valid
      && push_data == $past(nxt2) ##3 done && pc_out == $past(abs_target, 4))
      else $error("direct call push or target wrong");
  chk_ret_pop:
    assert property (issue && op inside {exec_pkg::OP_POP_TO_PC_EXIT,
      exec_pkg::OP_INTERRUPT_EXIT} |-> ##1 pop_req ##3 done && pc_out == $past(stack_data, 2))
      else $error("return address or timing wrong");
  chk_iexit_enable:
    assert property (issue && op == exec_pkg::OP_INTERRUPT_EXIT |-> ##4 flags_we
      && flags_out[exec_pkg::FLAG_I]) else $error("interrupt exit left I clear");
  chk_cmp_single:
    assert property (issue && op inside {exec_pkg::OP_COMPARE, exec_pkg::OP_COMPARE_IMMEDIATE,
      exec_pkg::OP_COMPARE_WITH_BORROW} |-> ##1 done && flags_we && !busy && pc_out == $past(nxt))
      else $error("compare not one cycle");
  chk_skip_two_word:
    assert property (issue && op == exec_pkg::OP_EQUAL_SKIP && rd_val == rr_val
      && next_is_two_word |-> ##1 busy [*2] ##1 done && skip_taken && pc_out == $past(nxt3, 3))
      else $error("two word skip wrong");
  chk_skip_fall:
    assert property (issue && op == exec_pkg::OP_EQUAL_SKIP && rd_val != rr_val |-> ##1 done
      && !skip_taken && pc_out == $past(nxt)) else $error("unequal skip not falling through");
  chk_zero_taken:
    assert property (issue && op == exec_pkg::OP_ZERO_SET_BRANCH && status_in[exec_pkg::FLAG_Z]
      |-> ##1 busy ##1 done && branch_taken && !flags_we && pc_out == $past(rel_tgt, 2))
      else $error("zero branch not taken correctly");
  // main scenarios reached
  cov_iexit: cover property (issue && op == exec_pkg::OP_INTERRUPT_EXIT);
  cov_skip: cover property (done && skip_taken);
  cov_branch: cover property (done && branch_taken);
endmodule

// *** testbench/stack_model.sv ***
// behavioural return-address stack on the far side of the execution unit
`timescale 1ns/100ps
module stack_model #(
  parameter int PC_W = 16
) (
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic            push_valid,
  input wire logic [PC_W-1:0] push_data,
  input wire logic            pop_req,
  output logic [PC_W-1:0]     stack_data
);
  logic [PC_W-1:0] mem[$];
  // pushes store, a pop shows its word in the next cycle, else the bus toggles
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_data <= '0;
    end else begin
      if (push_valid) begin
        mem.push_back(push_data);
      end
      if (pop_req && mem.size() > 0) begin
        stack_data <= mem.pop_back();
      end else begin
        stack_data <= ~stack_data;
      end
    end
  end
endmodule

// *** testbench/test_branch_skip_call_exec.sv ***
// self-checking bench for the control-flow execution unit
`timescale 1ns/100ps
module test_branch_skip_call_exec;
  localparam int PC_W = 16;
  localparam logic [13:0] POL = 14'h1665; // taken level of each fixed-flag branch
  typedef struct {logic [PC_W-1:0] pc; int at; logic sk; logic br; logic [7:0] fl;
                  logic [7:0] msk;} exp_t;
  logic            core_clk = 1'h0;
  logic            rst_n = 1'h0;
  logic            op_valid = 1'h0;
  logic            next_is_two_word = 1'h0;
  exec_pkg::op_t   op = exec_pkg::OP_COMPARE;
  logic [PC_W-1:0] pc_in = '0, abs_target = '0, z_pointer = '0, stack_data, pc_out, push_data;
  logic [11:0]     rel_offset = '0;
  logic [7:0]      rd_val = '0, rr_val = '0, imm_val = '0, io_data = '0, status_in = '0;
  logic [7:0]      flags_out;
  logic [2:0]      bit_sel = '0, flag_sel = '0;
  logic            busy, done, flags_we, push_valid, pop_req, skip_taken, branch_taken;
  int              n_fail = 0, n_checks = 0, cyc = 0;
  logic [31:0]     seed = 32'h8cdc_523c;
  exp_t            expq[$];
  exp_t            m;
  logic [PC_W-1:0] shadow[$];

  branch_skip_call_exec #(.PC_W(PC_W)) i_dut (.core_clk, .rst_n, .op_valid, .op, .pc_in,
    .rel_offset, .abs_target, .z_pointer, .rd_val, .rr_val, .imm_val, .bit_sel, .flag_sel,
    .io_data, .status_in, .next_is_two_word, .stack_data, .busy, .done, .pc_out, .flags_we,
    .flags_out, .push_valid, .push_data, .pop_req, .skip_taken, .branch_taken);
  stack_model #(.PC_W(PC_W)) i_stack (.core_clk, .rst_n, .push_valid, .push_data, .pop_req,
    .stack_data);

  // clock and cycle count
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // drive one operation with random operands, note its result, hold refused junk while busy
  task automatic issue(input exec_pkg::op_t o);
    logic [31:0]     r;
    logic [7:0]      rd, rr, io, st, opd;
    logic [8:0]      d;
    logic [4:0]      h;
    logic [11:0]     k;
    logic [2:0]      b, f;
    logic [PC_W-1:0] pc, kt;
    logic            t, ci, cz, v;
    int              n;
    exp_t            e;
    if (o inside {exec_pkg::OP_POP_TO_PC_EXIT, exec_pkg::OP_INTERRUPT_EXIT} && shadow.size() == 0)
      o = exec_pkg::OP_RELATIVE_JUMP_LINK;
    r = xs(seed);
    seed = xs(r);
    rd = r[7:0];
    rr = r[30] ? rd : r[15:8];
    io = r[23:16];
    b = r[26:24];
    f = r[29:27];
    st = seed[31:24];
    pc = seed[15:0];
    k = {{5{seed[22]}}, seed[22:16]};
    kt = pc + {{(PC_W-12){k[11]}}, k} + 1'h1;
    ci = (o == exec_pkg::OP_COMPARE_WITH_BORROW) && st[0];
    cz = (o != exec_pkg::OP_COMPARE_WITH_BORROW) || st[1];
    opd = (o == exec_pkg::OP_COMPARE_IMMEDIATE) ? io : rr;
    d = {1'h0, rd} - {1'h0, opd} - {8'h00, ci};
    h = {1'h0, rd[3:0]} - {1'h0, opd[3:0]} - {4'h0, ci};
    v = (rd[7] ^ opd[7]) & (rd[7] ^ d[7]);
    e = '{pc + 1'h1, 0, 1'h0, 1'h0, 8'h00, 8'h00};
    case (o)
      exec_pkg::OP_EQUAL_SKIP: t = rd == rr;
      exec_pkg::OP_REG_BIT_CLEAR_SKIP: t = !rr[b];
      exec_pkg::OP_REG_BIT_SET_SKIP: t = rr[b];
      exec_pkg::OP_IO_BIT_CLEAR_SKIP: t = !io[b];
      exec_pkg::OP_IO_BIT_SET_SKIP: t = io[b];
      exec_pkg::OP_FLAG_SET_BRANCH: t = st[f];
      exec_pkg::OP_FLAG_CLEAR_BRANCH: t = !st[f];
      exec_pkg::OP_ZERO_SET_BRANCH, exec_pkg::OP_ZERO_CLEAR_BRANCH: t = st[1];
      exec_pkg::OP_NEGATIVE_BRANCH, exec_pkg::OP_NONNEGATIVE_BRANCH: t = st[2];
      exec_pkg::OP_SIGNED_GE_BRANCH, exec_pkg::OP_SIGNED_LT_BRANCH: t = st[2] ^ st[3];
      exec_pkg::OP_HALF_CARRY_SET_BRANCH, exec_pkg::OP_HALF_CARRY_CLEAR_BRANCH: t = st[5];
      exec_pkg::OP_TRANSFER_BIT_SET_BRANCH, exec_pkg::OP_TRANSFER_BIT_CLEAR_BRANCH: t = st[6];
      default: t = st[0];
    endcase
    if (int'(o) >= 15) t = (t == POL[int'(o) - 15]);
    case (o)
      exec_pkg::OP_RELATIVE_JUMP_LINK, exec_pkg::OP_POINTER_JUMP_LINK: begin
        n = 3;
        e.pc = (o == exec_pkg::OP_RELATIVE_JUMP_LINK) ? kt : ~r[15:0];
        shadow.push_back(pc + 1'h1);
      end
      exec_pkg::OP_DIRECT_JUMP_LINK: begin
        n = 4;
        e.pc = r[15:0];
        shadow.push_back(pc + 2'h2);
      end
      exec_pkg::OP_POP_TO_PC_EXIT, exec_pkg::OP_INTERRUPT_EXIT: begin
        n = 4;
        e.pc = shadow.pop_back();
        e.msk = (o == exec_pkg::OP_INTERRUPT_EXIT) ? 8'h80 : 8'h00;
        e.fl = e.msk;
      end
      exec_pkg::OP_COMPARE, exec_pkg::OP_COMPARE_WITH_BORROW, exec_pkg::OP_COMPARE_IMMEDIATE: begin
        n = 1;
        e.msk = 8'h3f;
        e.fl = {2'h0, h[4], d[7] ^ v, v, d[7], cz && d[7:0] == 8'h00, d[8]};
      end
      exec_pkg::OP_EQUAL_SKIP, exec_pkg::OP_REG_BIT_CLEAR_SKIP, exec_pkg::OP_REG_BIT_SET_SKIP,
      exec_pkg::OP_IO_BIT_CLEAR_SKIP, exec_pkg::OP_IO_BIT_SET_SKIP: begin
        n = t ? (r[31] ? 3 : 2) : 1;
        e.sk = t;
        e.pc = pc + n[1:0];
      end
      default: begin
        n = t ? 2 : 1;
        e.br = t;
        e.pc = t ? kt : pc + 1'h1;
      end
    endcase
    e.at = cyc + n + 1;
    expq.push_back(e);
    op_valid <= 1'h1;
    op <= o;
    pc_in <= pc;
    rel_offset <= k;
    abs_target <= r[15:0];
    z_pointer <= ~r[15:0];
    rd_val <= rd;
    rr_val <= rr;
    imm_val <= io;
    io_data <= io;
    bit_sel <= b;
    flag_sel <= f;
    status_in <= st;
    next_is_two_word <= r[31];
    repeat (n - 1) begin
      @(posedge core_clk);
      op <= exec_pkg::OP_RELATIVE_JUMP_LINK;
      pc_in <= ~pc;
    end
    @(posedge core_clk);
  endtask

  // compare every completion with the oldest note
  always @(posedge core_clk) begin
    if (done === 1'h1) begin
      if (expq.size() == 0) begin
        check("spare done", 32'h1, 32'h0);
      end else begin
        m = expq.pop_front();
        check("done cycle", cyc, m.at);
        check("pc_out", 32'(pc_out), 32'(m.pc));
        check("skip_taken", 32'(skip_taken), 32'(m.sk));
        check("branch_taken", 32'(branch_taken), 32'(m.br));
        check("flags_we", 32'(flags_we), 32'(m.msk != 8'h00));
        check("flags_out", 32'(flags_out & m.msk), 32'(m.fl));
      end
    end
  end

  // reset, then every operation in turn with fresh operands, issued back to back
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    for (int i = 0; i < 580; i++) begin
      issue(exec_pkg::op_t'(i % 29));
    end
    op_valid <= 1'h0;
    repeat (8) @(posedge core_clk);
    check("pending", 32'(expq.size()), 32'h0);
    report_and_stop();
  end

  // guard against a hang
  initial begin
    repeat (8000) @(posedge core_clk);
    check("watchdog", 32'h1, 32'h0);
    report_and_stop();
  end
endmodule

bind branch_skip_call_exec exec_checker #(.PC_W(PC_W)) i_chk (.core_clk, .rst_n, .op_valid, .op,
  .pc_in, .rel_offset, .abs_target, .z_pointer, .rd_val, .rr_val, .status_in, .next_is_two_word,
  .stack_data, .busy, .done, .pc_out, .flags_we, .flags_out, .push_valid, .push_data, .pop_req,
  .skip_taken, .branch_taken);
